// ==== rtl/cmd_decoder_pkg.sv ====
/*
 * Constants, types and command codes shared by the command decoder.
 * Assumes a single synchronous clock domain and no bus-visible
 * registers beyond those listed here.
 */
// Overview of operation
// - Commands use only pins sampled at edges
// - Strobe patterns map to eight commands
// - Field widths follow density and organisation
// - Reset pin is asynchronous only, held high
// - Termination enable never affects decoding
// - Bank select picks one of four mode registers
// - Precharge closes one bank or all banks
// - Burst chop selects lengths, auto precharge closes the bank
// - Bursts count down, reloaded by each new read or write
// - Idle command leaves operations unaffected
// - Deselect ignores pins, acts as idle
// - Self refresh entry on enable falling
// - Self refresh exit on enable rising, sampled at the clock edge
// - Power-down entry and exit on enable edges
// - Calibration long or short by auto precharge bit
package cmd_decoder_pkg;

    // ****************************************************************
    // Organisation
    // ****************************************************************
    localparam int BANK_BITS            = 3;
    localparam int ADDR_BITS            = 16;
    localparam int MR_COUNT             = 4;
    localparam int MR_BITS              = 16;
    localparam int AUTO_PRE_POS         = 10;
    localparam int CHOP_POS             = 12;
    localparam int BURST_FIELD_LSB      = 0;
    localparam int BURST_COUNT_BITS     = 3;
    localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
    localparam logic [1:0] BURST_ON_THE_FLY  = 2'h1;
    localparam logic [1:0] BURST_FIXED_FOUR  = 2'h2;
    localparam logic [BURST_COUNT_BITS-1:0] BEATS_EIGHT = 3'h4;
    localparam logic [BURST_COUNT_BITS-1:0] BEATS_FOUR  = 3'h2;
    localparam logic [MR_BITS-1:0] MR_RESET = 16'h0000;

    // ****************************************************************
    // Register map (APB byte addresses)
    // ****************************************************************
    localparam logic [7:0] OFF_STATUS    = 8'h00;
    localparam logic [7:0] OFF_LASTCMD   = 8'h04;
    localparam logic [7:0] OFF_BANKOPEN  = 8'h08;
    localparam logic [7:0] OFF_CONFIG    = 8'h0C;
    localparam logic [7:0] OFF_MR_BASE   = 8'h10;
    localparam logic [7:0] OFF_CALCOUNT  = 8'h20;
    localparam logic [1:0] CONFIG_RESET  = 2'h0;

    // ****************************************************************
    // Decoded commands and power states
    // ****************************************************************
    typedef enum logic [4:0] {
        CMD_DESELECT, CMD_IDLE, CMD_MODE_WRITE, CMD_REFRESH, CMD_SELF_ENTER,
        CMD_SELF_EXIT, CMD_PRECHARGE, CMD_PRECHARGE_ALL, CMD_ROW_OPEN,
        CMD_WRITE, CMD_READ, CMD_PD_ENTER, CMD_PD_EXIT, CMD_CAL_LONG,
        CMD_CAL_SHORT, CMD_ILLEGAL
    } command_type;

    typedef enum logic [1:0] {
        PWR_ACTIVE, PWR_POWERDOWN, PWR_SELF_REFRESH
    } power_type;

endpackage : cmd_decoder_pkg

// ==== rtl/sdram_command_decoder.sv ====
/*
 * Command decoder of a DDR synchronous DRAM, with an APB slave for
 * status and mode register readback.
 * Assumes command pins are synchronous to pclk and the APB master
 * follows the standard two-phase protocol.
 */
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sdram_command_decoder
    import cmd_decoder_pkg::*;
(
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // Memory command pins
    input  wire logic                  chip_select_n,
    input  wire logic                  row_strobe_n,
    input  wire logic                  column_strobe_n,
    input  wire logic                  write_enable_n,
    input  wire logic                  clock_enable_in,
    input  wire logic                  termination_enable,
    input  wire logic [BANK_BITS-1:0]  bank_select,
    input  wire logic [ADDR_BITS-1:0]  address,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Decoded command outputs
    output logic                       cmd_valid,
    output command_type                cmd_code,
    output logic [BANK_BITS-1:0]       cmd_bank,
    output logic [ADDR_BITS-1:0]       cmd_address,
    output logic                       cmd_auto_precharge,
    output logic                       cmd_chop,
    output logic                       burst_busy,
    output power_type                  power_state
);

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed {
        logic                               cke_prev;      // Enable at last edge
        power_type                          power;         // Power state
        logic [(1<<BANK_BITS)-1:0]          bank_open;     // Open rows per bank
        logic [MR_COUNT-1:0][MR_BITS-1:0]   mode_reg;      // Mode registers
        logic [BURST_COUNT_BITS-1:0]        burst_left;    // Remaining burst beats
        logic                               init_done;     // First long cal seen
        logic [15:0]                        cal_count;     // Calibrations seen
        logic [1:0]                         config_reg;    // Software config
        logic                               cmd_valid;     // Decoded strobe
        command_type                        cmd_code;      // Last command
        logic [BANK_BITS-1:0]               cmd_bank;      // Last bank
        logic [ADDR_BITS-1:0]               cmd_address;   // Last address
        logic                               cmd_ap;        // Last auto close
        logic                               cmd_chop;      // Last chop select
        logic                               cal_init;      // Last long cal in init
        logic [31:0]                        prdata;        // Read data
    } state_type;

    state_type state;       // Registered state
    state_type next_state;  // Next value

    command_type decoded;   // Present-edge command
    logic        cke_rise;  // Enable low to high
    logic        cke_fall;  // Enable high to low
    logic        is_idle;   // Idle pattern on strobes
    logic        on_the_fly; // On-the-fly burst select
    logic [1:0]  bl_mode;   // Burst mode field
    logic        apb_write; // Write access phase
    logic        apb_read;  // Read setup phase
    logic        addr_ok;   // Mapped address

    // ****************************************************************
    // Command decode
    // ****************************************************************
    // Decode from the sampled pins and the power state; termination_enable is unused
    always_comb begin
        cke_rise = !state.cke_prev && clock_enable_in;
        cke_fall = state.cke_prev && !clock_enable_in;
        is_idle  = !chip_select_n && row_strobe_n && column_strobe_n && write_enable_n;
        decoded  = CMD_ILLEGAL;
        if (cke_rise) begin
            // Enable rising: exit either low-power state
            if (chip_select_n || is_idle) begin
                decoded = (state.power == PWR_SELF_REFRESH) ? CMD_SELF_EXIT : CMD_PD_EXIT;
            end
        end else if (!state.cke_prev) begin
            // Enable held low: pins are ignored
            decoded = CMD_DESELECT;
        end else if (cke_fall) begin
            if (!chip_select_n && !row_strobe_n && !column_strobe_n && write_enable_n) begin
                decoded = CMD_SELF_ENTER;
            end else if (chip_select_n || is_idle) begin
                decoded = CMD_PD_ENTER;
            end
        end else if (chip_select_n) begin
            decoded = CMD_DESELECT;
        end else begin
            // Strobe code: row, column, write
            case ({row_strobe_n, column_strobe_n, write_enable_n})
                3'h0: decoded = CMD_MODE_WRITE;
                3'h1: decoded = CMD_REFRESH;
                3'h2: decoded = address[AUTO_PRE_POS] ? CMD_PRECHARGE_ALL
                                                      : CMD_PRECHARGE;
                3'h3: decoded = CMD_ROW_OPEN;
                3'h4: decoded = CMD_WRITE;
                3'h5: decoded = CMD_READ;
                3'h6: decoded = address[AUTO_PRE_POS] ? CMD_CAL_LONG
                                                      : CMD_CAL_SHORT;
                default: decoded = CMD_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign apb_write = psel && penable && pwrite;
    assign apb_read  = psel && !penable && !pwrite;
    assign bl_mode    = state.mode_reg[0][BURST_FIELD_LSB +: 2];
    assign on_the_fly = (bl_mode == BURST_ON_THE_FLY);

    // Mapped addresses answer, others flag an error
    always_comb begin
        if (paddr == OFF_STATUS) begin
            addr_ok = 1'b1;
        end else if (paddr == OFF_LASTCMD || paddr == OFF_BANKOPEN) begin
            addr_ok = 1'b1;
        end else if (paddr == OFF_CONFIG || paddr == OFF_CALCOUNT) begin
            addr_ok = 1'b1;
        end else if (paddr >= OFF_MR_BASE && paddr < OFF_CALCOUNT && paddr[1:0] == 2'h0) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_state           = state;
        next_state.cke_prev  = clock_enable_in;
        next_state.cmd_valid = 1'b0;
        // Burst counts down; a new read or write reloads it
        if (state.burst_left != '0) begin
            next_state.burst_left = state.burst_left - 3'h1;
        end
        if (decoded != CMD_DESELECT && decoded != CMD_IDLE) begin
            next_state.cmd_valid   = 1'b1;
            next_state.cmd_code    = decoded;
            next_state.cmd_bank    = bank_select;
            next_state.cmd_address = address;
            next_state.cmd_ap      = address[AUTO_PRE_POS];
            next_state.cmd_chop    = 1'b0;
        end
        case (decoded)
            CMD_MODE_WRITE: begin
                next_state.mode_reg[bank_select[1:0]] = address;
            end
            CMD_ROW_OPEN: begin
                next_state.bank_open[bank_select] = 1'b1;
            end
            CMD_PRECHARGE: begin
                next_state.bank_open[bank_select] = 1'b0;
            end
            CMD_PRECHARGE_ALL: begin
                next_state.bank_open = '0;
            end
            CMD_READ, CMD_WRITE: begin
                // Burst length by mode or by the chop pin
                if (on_the_fly) begin
                    next_state.cmd_chop   = !address[CHOP_POS];
                    next_state.burst_left = address[CHOP_POS] ? BEATS_EIGHT : BEATS_FOUR;
                end else begin
                    next_state.cmd_chop   = (bl_mode == BURST_FIXED_FOUR);
                    next_state.burst_left = (bl_mode == BURST_FIXED_FOUR) ? BEATS_FOUR
                                                                          : BEATS_EIGHT;
                end
                if (address[AUTO_PRE_POS]) begin
                    next_state.bank_open[bank_select] = 1'b0;
                end
            end
            CMD_CAL_LONG: begin
                next_state.cal_init  = !state.init_done;
                next_state.init_done = 1'b1;
                next_state.cal_count = state.cal_count + 16'h0001;
            end
            CMD_CAL_SHORT: begin
                next_state.cal_count = state.cal_count + 16'h0001;
            end
            CMD_SELF_ENTER: begin
                next_state.power = PWR_SELF_REFRESH;
            end
            CMD_PD_ENTER: begin
                next_state.power = PWR_POWERDOWN;
            end
            CMD_SELF_EXIT, CMD_PD_EXIT: begin
                next_state.power = PWR_ACTIVE;
            end
            default: begin
                // Idle and deselect leave work in flight alone
                next_state.power = state.power;
            end
        endcase
        // Software write to the config register
        if (apb_write && paddr == OFF_CONFIG) begin
            next_state.config_reg = pwdata[1:0];
        end
        // Read data captured in the setup phase
        if (apb_read) begin
            if (paddr == OFF_STATUS) begin
                next_state.prdata = {24'h0, state.init_done, state.cal_init,
                                     state.burst_left != '0, 1'b0, state.power, 2'h0};
            end else if (paddr == OFF_LASTCMD) begin
                next_state.prdata = {2'h0, state.cmd_chop, state.cmd_ap, 3'h0,
                                     state.cmd_bank, state.cmd_address[15:0], 1'b0,
                                     state.cmd_code};
            end else if (paddr == OFF_BANKOPEN) begin
                next_state.prdata = {24'h0, state.bank_open};
            end else if (paddr == OFF_CONFIG) begin
                next_state.prdata = {30'h0, state.config_reg};
            end else if (paddr == OFF_CALCOUNT) begin
                next_state.prdata = {16'h0, state.cal_count};
            end else if (addr_ok) begin
                next_state.prdata = {16'h0, state.mode_reg[paddr[3:2]]};
            end else begin
                next_state.prdata = 32'h0000_0000;
            end
        end
        // Config bit 0 clears the calibration counter
        if (state.config_reg[0]) begin
            next_state.cal_count = 16'h0000;
        end
    end

    // ****************************************************************
    // State register; presetn is the only reset
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state            <= '0;
            state.power      <= PWR_ACTIVE;
            state.cmd_code   <= CMD_DESELECT;
            state.config_reg <= CONFIG_RESET;
            state.mode_reg   <= '{default: MR_RESET};
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign pready             = 1'b1;
    assign pslverr            = psel && penable && !addr_ok;
    assign prdata             = state.prdata;
    assign cmd_valid          = state.cmd_valid;
    assign cmd_code           = state.cmd_code;
    assign cmd_bank           = state.cmd_bank;
    assign cmd_address        = state.cmd_address;
    assign cmd_auto_precharge = state.cmd_ap;
    assign cmd_chop           = state.cmd_chop;
    assign burst_busy         = state.burst_left != '0;
    assign power_state        = state.power;

endmodule : sdram_command_decoder

`default_nettype wire

// ==== tb/cmd_decoder_chk.sv ====
/* Assertion checker for the command decoder, watching its top ports.
   Assumes one clock domain and a bind onto the decoder top. */
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_chk
    import cmd_decoder_pkg::*;
(
    // Clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // Command pins
    input wire logic                 chip_select_n,
    input wire logic                 row_strobe_n,
    input wire logic                 column_strobe_n,
    input wire logic                 write_enable_n,
    input wire logic                 clock_enable_in,
    input wire logic [BANK_BITS-1:0] bank_select,
    input wire logic [ADDR_BITS-1:0] address,
    // Decoded outputs
    input wire logic                 pslverr,
    input wire logic                 cmd_valid,
    input wire command_type          cmd_code,
    input wire logic [BANK_BITS-1:0] cmd_bank,
    input wire logic                 cmd_auto_precharge,
    input wire logic                 cmd_chop,
    input wire logic                 burst_busy,
    input wire power_type            power_state
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic       cke_q; // Enable seen at the previous edge, low out of reset
    logic [3:0] pat;   // Select and strobe pattern
    logic       run;   // Enable high at both edges
    assign pat = {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n};
    assign run = cke_q && clock_enable_in;
    // Track the enable level of the previous edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cke_q <= 1'b0;
        else cke_q <= clock_enable_in;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_read_decode: assert property (run && pat == 4'h5 |=> cmd_valid &&
        cmd_code == CMD_READ && cmd_bank == $past(bank_select)) else $error("read not decoded");
    a_write_ap: assert property (run && pat == 4'h4 |=> cmd_code == CMD_WRITE &&
        cmd_auto_precharge == $past(address[AUTO_PRE_POS])) else $error("write decode wrong");
    a_mode_bank: assert property (run && pat == 4'h0 |=> cmd_valid &&
        cmd_code == CMD_MODE_WRITE && cmd_bank == $past(bank_select)) else $error("mode bank wrong");
    a_prech_scope: assert property (run && pat == 4'h2 |=> cmd_code ==
        ($past(address[AUTO_PRE_POS]) ? CMD_PRECHARGE_ALL : CMD_PRECHARGE)) else $error("precharge scope");
    a_cal_length: assert property (run && pat == 4'h6 |=> cmd_code ==
        ($past(address[AUTO_PRE_POS]) ? CMD_CAL_LONG : CMD_CAL_SHORT)) else $error("cal length");
    a_idle_quiet: assert property (run && pat == 4'h7 |=> !cmd_valid)
        else $error("idle gave a command");
    a_desel_quiet: assert property (run && chip_select_n |=> !cmd_valid)
        else $error("deselect gave a command");
    a_self_enter: assert property (cke_q && !clock_enable_in && pat == 4'h1
        |=> power_state == PWR_SELF_REFRESH) else $error("self refresh not entered");
    a_pd_enter: assert property (cke_q && !clock_enable_in && (chip_select_n || pat == 4'h7)
        |=> power_state == PWR_POWERDOWN) else $error("power-down not entered");
    a_wake_exit: assert property (!cke_q && clock_enable_in && (chip_select_n || pat == 4'h7)
        |=> power_state == PWR_ACTIVE) else $error("wake not taken");
    a_burst_runs: assert property (run && (pat == 4'h4 || pat == 4'h5) |=> burst_busy[*2])
        else $error("burst cut short");
    // Main scenarios reached
    c_chop_read: cover property (cmd_valid && cmd_code == CMD_READ && cmd_chop);
    c_self: cover property (power_state == PWR_SELF_REFRESH);
    c_err: cover property (pslverr);
endmodule : cmd_decoder_chk
bind sdram_command_decoder cmd_decoder_chk chk (.pclk(pclk), .presetn(presetn),
    .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_enable_n(write_enable_n), .clock_enable_in(clock_enable_in), .bank_select(bank_select),
    .address(address), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .cmd_auto_precharge(cmd_auto_precharge), .cmd_chop(cmd_chop),
    .burst_busy(burst_busy), .power_state(power_state));
`default_nettype wire

// ==== tb/ctrl_model.sv ====
/* Memory controller model driving the decoder's command pins.
   Assumes one issue call at a time. */
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
    import cmd_decoder_pkg::*;
(
    // Clock
    input  wire logic                 pclk,
    // Command pins toward the decoder
    output var logic                  chip_select_n,
    output var logic                  row_strobe_n,
    output var logic                  column_strobe_n,
    output var logic                  write_enable_n,
    output var logic                  clock_enable_in,
    output var logic [BANK_BITS-1:0]  bank_select,
    output var logic [ADDR_BITS-1:0]  address
);
    // ****************************************************************
    // Pin driving
    // ****************************************************************
    // Idle pattern with enable up before reset is released
    initial begin
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= 4'h7;
        clock_enable_in <= 1'b1;
        bank_select <= '0;
        address <= '0;
    end
    // One command for one edge, then idle with the enable level kept
    task automatic issue(input logic [3:0] p, input logic cke, input logic [2:0] ba,
                         input logic [15:0] a);
        @(posedge pclk);
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= p;
        clock_enable_in <= cke;
        bank_select <= ba;
        address <= a;
        @(posedge pclk);
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} <= 4'h7;
        bank_select <= ~ba; // Stale fields inverted so old values never linger
        address <= ~a;
    endtask : issue
endmodule : ctrl_model
`default_nettype wire

// ==== tb/tb_top.sv ====
/* Self-checking bench for the command decoder: APB tasks and command calls.
   Assumes the controller model and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cmd_decoder_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic pclk = 1'b0, presetn = 1'b0, termination_enable = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic cs_n, ras_n, cas_n, we_n, cke, err, cmd_valid, cmd_ap, cmd_chop, burst_busy;
    logic [2:0]  ba, cmd_bank;
    logic [15:0] ad, cmd_address;
    command_type cmd_code;
    power_type   power_state;
    int error_cnt = 0, n_tests = 0, i, j, n;
    always #25 pclk = ~pclk; // 20 MHz
    ctrl_model ctl (.pclk(pclk), .chip_select_n(cs_n), .row_strobe_n(ras_n),
        .column_strobe_n(cas_n), .write_enable_n(we_n), .clock_enable_in(cke),
        .bank_select(ba), .address(ad));
    sdram_command_decoder uut (.pclk(pclk), .presetn(presetn), .chip_select_n(cs_n),
        .row_strobe_n(ras_n), .column_strobe_n(cas_n), .write_enable_n(we_n),
        .clock_enable_in(cke), .termination_enable(termination_enable), .bank_select(ba),
        .address(ad), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
        .cmd_address(cmd_address), .cmd_auto_precharge(cmd_ap), .cmd_chop(cmd_chop),
        .burst_busy(burst_busy), .power_state(power_state));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Verdict and end of run
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report
    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One APB transfer, bounded wait for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            error_cnt++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Issue a command, check its decode
    task automatic cmd(input logic [3:0] p, input logic [2:0] b, input logic [15:0] a,
                       input logic v, input command_type c);
        ctl.issue(p, 1'b1, b, a);
        termination_enable <= ~termination_enable;
        @(negedge pclk);
        chk("cmd_valid", v, cmd_valid);
        chk("cmd_code", c, cmd_code);
        if (v) chk("cmd_address", a, cmd_address);
    endtask : cmd
    // ****************************************************************
    // Tables
    // ****************************************************************
    logic [3:0]  tp[6] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'h6, 4'h6};
    logic [15:0] ta[6] = '{16'h0000, 16'h0000, 16'h0400, 16'h1234, 16'h0400, 16'h0000};
    command_type tc[6] = '{CMD_REFRESH, CMD_PRECHARGE, CMD_PRECHARGE_ALL, CMD_ROW_OPEN,
                           CMD_CAL_LONG, CMD_CAL_SHORT};
    // Burst rows: mode word, pattern, address, chop expected, beats expected
    logic [15:0] bm[6] = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h2, 16'h0};
    logic [3:0]  bp[6] = '{4'h5, 4'h5, 4'h4, 4'h4, 4'h5, 4'h4};
    logic [15:0] bx[6] = '{16'h0000, 16'h1400, 16'h0400, 16'h1000, 16'h1000, 16'h0000};
    logic        bc[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int          bn[6] = '{2, 4, 2, 4, 2, 4};
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        final_report();
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (8) @(posedge pclk);
        chk("reset power", PWR_ACTIVE, power_state);
        chk("reset valid", 0, cmd_valid);
        presetn <= 1'b1; // Held high from here on
        repeat (2) @(posedge pclk);
        for (i = 0; i < 4; i++) begin
            cmd(4'h0, i[2:0], 16'h1230 + i[15:0], 1'b1, CMD_MODE_WRITE);
            apb(1'b0, OFF_MR_BASE + 8'(4 * i), 32'h0);
            chk("mode reg", 32'h1230 + i, rd);
        end
        $display("test mode registers done");
        for (i = 0; i < 6; i++) begin
            cmd(tp[i], 3'h5, ta[i], 1'b1, tc[i]);
            if (tc[i] == CMD_PRECHARGE || tc[i] == CMD_ROW_OPEN) chk("bank", 3'h5, cmd_bank);
        end
        $display("test command table done");
        for (i = 0; i < 6; i++) begin
            cmd(4'h0, 3'h0, bm[i], 1'b1, CMD_MODE_WRITE);
            ctl.issue(bp[i], 1'b1, 3'h2, bx[i]);
            n = 0;
            fork
                ctl.issue(4'h8, 1'b1, 3'h7, 16'hFFFF);
                for (j = 0; j < 10; j++) begin
                    @(negedge pclk);
                    if (j == 0) begin
                        chk("burst code", (bp[i] == 4'h5) ? CMD_READ : CMD_WRITE, cmd_code);
                        chk("chop", bc[i], cmd_chop);
                        chk("auto precharge", bx[i][10], cmd_ap);
                    end
                    if (burst_busy === 1'b1) n++;
                end
            join
            chk("beats", bn[i], n);
        end
        cmd(4'h7, 3'h1, 16'h0001, 1'b0, CMD_WRITE);
        cmd(4'h8, 3'h6, 16'hFFFE, 1'b0, CMD_WRITE);
        $display("test bursts done");
        ctl.issue(4'h1, 1'b0, 3'h0, 16'h0);
        @(negedge pclk);
        chk("self enter", PWR_SELF_REFRESH, power_state);
        ctl.issue(4'h8, 1'b1, 3'h3, 16'h0F0F);
        @(negedge pclk);
        chk("self exit", PWR_ACTIVE, power_state);
        chk("self exit code", CMD_SELF_EXIT, cmd_code);
        ctl.issue(4'h7, 1'b0, 3'h0, 16'h0);
        @(negedge pclk);
        chk("pd enter", PWR_POWERDOWN, power_state);
        ctl.issue(4'h7, 1'b1, 3'h0, 16'h0);
        @(negedge pclk);
        chk("pd exit", PWR_ACTIVE, power_state);
        chk("pd exit code", CMD_PD_EXIT, cmd_code);
        $display("test power states done");
        for (i = 0; i < 2; i++) begin
            apb(i[0], 8'h40, 32'hA5A5A5A5);
            chk("unmapped err", 1, err);
            if (i == 0) chk("unmapped data", 0, rd);
        end
        $display("test register bus done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
